// >>> rts_regs.vh
// Register offsets, field positions, reset values and timing counts for
// the resistive touch scanner. Included by the scanner; holds definitions.
`ifndef RTS_REGS_VH
`define RTS_REGS_VH

// Register offsets (word index on the plain register port)
`define RTS_STAT1_ADDR 4'h0
`define RTS_STAT2_ADDR 4'h1
`define RTS_CFG_ADDR 4'h2
`define RTS_TRIG_ADDR 4'h3
`define RTS_PERIOD_ADDR 4'h4
`define RTS_SETTLE_ADDR 4'h5
`define RTS_HRES_ADDR 4'h6
`define RTS_VRES_ADDR 4'h7
`define RTS_XCOORD_ADDR 4'h8
`define RTS_YCOORD_ADDR 4'h9
`define RTS_PRESS_ADDR 4'ha

// First status register fields
`define RTS_EV_SAMPLE 0
`define RTS_EV_RELEASE 1
`define RTS_ST_TWO 6
`define RTS_ST_TOUCHED 7

// Configuration fields
`define RTS_CFG_PRESS 0
`define RTS_CFG_ZOOM 1
`define RTS_CFG_ROTATE 2

// Second status register fields
`define RTS_ST2_FIVE 0
`define RTS_ST2_MODE_LO 1

// Reset values
`define RTS_PERIOD_RST 8'h0a
`define RTS_SETTLE_RST 8'h10
`define RTS_RES_RST 16'h1000

// Timing
`define RTS_CLK_HZ 25000000
`define RTS_PERIOD_MIN_MS 8'h05
`define RTS_PERIOD_MAX_MS 8'h64
`define RTS_MS_CYC (`RTS_CLK_HZ / 1000)
`define RTS_ADC_MAX 12'hfff

`endif

// >>> rts_scanner.v
// Resistive touch scanner: drives panel terminals, sequences settle and
// sample phases, scales coordinates and latches events for the host.
// Assumes an external converter returning a 12-bit sample on request and a
// comparator reporting touch; panel pins are asynchronous to clock_i.
`include "rts_regs.vh"

// Notes on behaviour
// - Four-wire X: X+ high, X- low, Y floating; Y is the reverse.
// - Five-wire X: right corners high, left low; Y: upper high, lower low.
// - Origin is at X-/Y- meeting, or lower-left corner on five-wire.
// - Sequence is XY, XY plus pressure, or extended when gestures enabled.
// - Wait a programmable settle time before every sample.
// - Scan repeats every programmed period, 5 ms to 100 ms.
// - Scan only while touched; otherwise stay in standby.
// - Default 4096 points per axis; written resolutions scale X and Y.
// - Detect four- or five-wire panel and report it in status two.
// - Pressure and gestures cannot be enabled on a five-wire panel.
// - Each event latches its own bit until status one is read.
// - Enabled latched event asserts alert until status one is read.
// - New-sample event on touch detection, then once per period.
// - Release event only on touched-to-untouched; coordinates kept.
// - Touched and two-touch bits refresh each period, never latch.
// - Touched and new-sample set only after coordinates are written.
// - On release, new-sample set once more and touched cleared.
// - After release no further events until a new touch.
// - Alert output is active low.
module rts_scanner #(
   parameter [31:0] MS_CYC = `RTS_MS_CYC
) (
   input wire clock_i,
   input wire rst_i,
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   input wire touch_i,
   input wire five_wire_i,
   input wire two_touch_i,
   output reg adc_start_o,
   input wire adc_done_i,
   input wire [11:0] adc_data_i,
   output reg [1:0] adc_chan_o,
   output reg [3:0] term_drive_o,
   output reg [3:0] term_oe_o,
   output reg corner_upper_right_o,
   output reg corner_upper_left_o,
   output reg corner_lower_right_o,
   output reg corner_lower_left_o,
   output reg event_alert_n_o
);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_SETTLE = 7'h02;
   localparam [6:0] S_CONV = 7'h04;
   localparam [6:0] S_SCALE = 7'h08;
   localparam [6:0] S_POST = 7'h10;
   localparam [6:0] S_WAIT = 7'h20;
   localparam [6:0] S_PROBE = 7'h40;

   // Channel order within a sequence
   localparam [1:0] CH_X = 2'd0;
   localparam [1:0] CH_Y = 2'd1;
   localparam [1:0] CH_P = 2'd2;
   localparam [1:0] CH_G = 2'd3;

   // Three-stage synchronisers for pin inputs
   reg [2:0] touch_s_q;
   reg [2:0] five_s_q;
   reg [2:0] two_s_q;
   reg touch_q;
   reg five_q;
   reg two_q;

   reg [6:0] state_q;
   reg [1:0] chan_q;
   reg [31:0] cnt_q;
   reg [31:0] per_cnt_q;
   reg scanning_q;
   reg [2:0] cfg_q;
   reg [7:0] trig_q;
   reg [7:0] period_q;
   reg [7:0] settle_q;
   reg [15:0] hres_q;
   reg [15:0] vres_q;
   reg [15:0] hres_pend_q;
   reg hres_wr_q;
   reg [15:0] xres_q;
   reg [15:0] yres_q;
   reg [15:0] x_q;
   reg [15:0] y_q;
   reg [11:0] press_q;
   reg [11:0] raw_q;
   reg [1:0] ev_q;
   reg touched_q;
   reg two_st_q;

   wire rd_stat1 = rd_i && (addr_i == `RTS_STAT1_ADDR);
   wire [2:0] cfg_eff = five_q ? 3'h0 : cfg_q;
   wire gest_on = cfg_eff[`RTS_CFG_ZOOM] | cfg_eff[`RTS_CFG_ROTATE];
   wire [1:0] mode = gest_on ? 2'd2 :
      (cfg_eff[`RTS_CFG_PRESS] ? 2'd1 : 2'd0);
   wire [1:0] last_ch = gest_on ? CH_G :
      (cfg_eff[`RTS_CFG_PRESS] ? CH_P : CH_Y);
   wire [7:0] per_ms = (period_q < `RTS_PERIOD_MIN_MS) ?
      `RTS_PERIOD_MIN_MS : ((period_q > `RTS_PERIOD_MAX_MS) ?
      `RTS_PERIOD_MAX_MS : period_q);
   wire [31:0] per_cyc = per_ms * MS_CYC;
   wire [31:0] settle_cyc = {24'h0, settle_q} + 32'd1;
   wire [15:0] res_sel = (chan_q == CH_Y) ? yres_q : xres_q;
   wire [27:0] prod = raw_q * res_sel;
   wire [15:0] scaled = prod[27:12];
   wire [7:0] ev_new;
   wire [1:0] ev_set;

   // Event set wins over the read clear
   assign ev_new = {6'h0, ev_q | ev_set};

   // Event sources computed from the sequencer
   reg set_sample;
   reg set_release;
   assign ev_set = {set_release, set_sample};

   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         touch_s_q <= 3'h0;
         five_s_q <= 3'h0;
         two_s_q <= 3'h0;
         touch_q <= 1'b0;
         five_q <= 1'b0;
         two_q <= 1'b0;
      end else begin
         touch_s_q <= {touch_s_q[1:0], touch_i};
         five_s_q <= {five_s_q[1:0], five_wire_i};
         two_s_q <= {two_s_q[1:0], two_touch_i};
         if (touch_s_q[2] == touch_s_q[1]) touch_q <= touch_s_q[2];
         if (five_s_q[2] == five_s_q[1]) five_q <= five_s_q[2];
         if (two_s_q[2] == two_s_q[1]) two_q <= two_s_q[2];
      end
   end

   // Register writes
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= 3'h0;
         trig_q <= 8'h00;
         period_q <= `RTS_PERIOD_RST;
         settle_q <= `RTS_SETTLE_RST;
         hres_q <= `RTS_RES_RST;
         vres_q <= `RTS_RES_RST;
         hres_pend_q <= `RTS_RES_RST;
         hres_wr_q <= 1'b0;
      end else if (wr_i) begin
         case (addr_i)
            `RTS_CFG_ADDR: begin
               cfg_q <= five_q ? 3'h0 : wdata_i[2:0];
            end
            `RTS_TRIG_ADDR: begin
               trig_q <= wdata_i[7:0];
            end
            `RTS_PERIOD_ADDR: begin
               period_q <= wdata_i[7:0];
            end
            `RTS_SETTLE_ADDR: begin
               settle_q <= wdata_i[7:0];
            end
            `RTS_HRES_ADDR: begin
               hres_pend_q <= wdata_i;
               hres_wr_q <= 1'b1;
            end
            `RTS_VRES_ADDR: begin
               // Both resolutions take effect together
               if (hres_wr_q) begin
                  hres_q <= hres_pend_q;
                  vres_q <= wdata_i;
                  hres_wr_q <= 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Sequencer
   always @* begin
      set_sample = 1'b0;
      set_release = 1'b0;
      if (state_q == S_POST) set_sample = 1'b1;
      if ((state_q == S_WAIT || state_q == S_IDLE) && scanning_q &&
          !touch_q) begin
         set_sample = 1'b1;
         set_release = 1'b1;
      end
   end

   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         chan_q <= CH_X;
         cnt_q <= 32'h0;
         per_cnt_q <= 32'h0;
         scanning_q <= 1'b0;
         xres_q <= `RTS_RES_RST;
         yres_q <= `RTS_RES_RST;
         x_q <= 16'h0;
         y_q <= 16'h0;
         press_q <= 12'h0;
         raw_q <= 12'h0;
         touched_q <= 1'b0;
         two_st_q <= 1'b0;
         adc_start_o <= 1'b0;
         adc_chan_o <= CH_X;
      end else begin
         adc_start_o <= 1'b0;
         per_cnt_q <= (per_cnt_q == 32'h0) ? 32'h0 : per_cnt_q - 32'd1;
         case (state_q)
            S_IDLE: begin
               if (scanning_q && !touch_q) begin
                  scanning_q <= 1'b0;
                  touched_q <= 1'b0;
                  two_st_q <= 1'b0;
               end else if (touch_q) begin
                  xres_q <= hres_q;
                  yres_q <= vres_q;
                  per_cnt_q <= per_cyc;
                  chan_q <= CH_X;
                  cnt_q <= settle_cyc;
                  state_q <= S_SETTLE;
               end
            end
            S_SETTLE: begin
               if (cnt_q == 32'd1) begin
                  adc_start_o <= 1'b1;
                  adc_chan_o <= chan_q;
                  state_q <= S_CONV;
               end else begin
                  cnt_q <= cnt_q - 32'd1;
               end
            end
            S_CONV: begin
               if (adc_done_i) begin
                  raw_q <= adc_data_i;
                  state_q <= S_SCALE;
               end
            end
            S_SCALE: begin
               // Origin at the low terminal: raw zero maps to zero
               if (chan_q == CH_X) x_q <= scaled;
               if (chan_q == CH_Y) y_q <= scaled;
               if (chan_q == CH_P) press_q <= raw_q;
               if (chan_q == last_ch) begin
                  state_q <= S_POST;
               end else begin
                  chan_q <= chan_q + 2'd1;
                  cnt_q <= settle_cyc;
                  state_q <= S_SETTLE;
               end
            end
            S_POST: begin
               scanning_q <= 1'b1;
               touched_q <= 1'b1;
               two_st_q <= gest_on & two_q;
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (!touch_q) begin
                  scanning_q <= 1'b0;
                  touched_q <= 1'b0;
                  two_st_q <= 1'b0;
                  state_q <= S_IDLE;
               end else if (per_cnt_q == 32'h0) begin
                  state_q <= S_PROBE;
               end
            end
            S_PROBE: begin
               per_cnt_q <= per_cyc;
               chan_q <= CH_X;
               cnt_q <= settle_cyc;
               state_q <= S_SETTLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Terminal drive per channel and panel type
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         term_drive_o <= 4'h0;
         term_oe_o <= 4'h0;
         corner_upper_right_o <= 1'b0;
         corner_upper_left_o <= 1'b0;
         corner_lower_right_o <= 1'b0;
         corner_lower_left_o <= 1'b0;
      end else if (state_q == S_SETTLE || state_q == S_CONV) begin
         // Terminal order {y_neg, y_pos, x_neg, x_pos}; corners drive five-wire
         if (five_q) begin
            term_oe_o <= 4'h0;
            term_drive_o <= 4'h0;
            corner_upper_right_o <= 1'b1;
            corner_upper_left_o <= (chan_q == CH_Y);
            corner_lower_right_o <= (chan_q != CH_Y);
            corner_lower_left_o <= 1'b0;
         end else if (chan_q == CH_Y) begin
            term_oe_o <= 4'hc;
            term_drive_o <= 4'h4;
         end else if (chan_q == CH_X) begin
            term_oe_o <= 4'h3;
            term_drive_o <= 4'h1;
         end else begin
            // Pressure and gesture: X+ high, Y- low across the layers
            term_oe_o <= 4'h9;
            term_drive_o <= 4'h1;
         end
      end else begin
         term_oe_o <= 4'h0;
         term_drive_o <= 4'h0;
         corner_upper_right_o <= 1'b0;
         corner_upper_left_o <= 1'b0;
         corner_lower_right_o <= 1'b0;
         corner_lower_left_o <= 1'b0;
      end
   end

   // Events, alert and read data
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ev_q <= 2'h0;
         event_alert_n_o <= 1'b1;
         rdata_o <= 16'h0;
      end else begin
         ev_q <= rd_stat1 ? ev_set : ev_new[1:0];
         event_alert_n_o <= ~(|((rd_stat1 ? {6'h0, ev_set} : ev_new) &
            trig_q));
         rdata_o <= 16'h0;
         if (rd_i) begin
            case (addr_i)
               `RTS_STAT1_ADDR: rdata_o <= {8'h0, touched_q, two_st_q,
                  4'h0, ev_q};
               `RTS_STAT2_ADDR: rdata_o <= {13'h0, mode, five_q};
               `RTS_CFG_ADDR: rdata_o <= {13'h0, cfg_eff};
               `RTS_TRIG_ADDR: rdata_o <= {8'h0, trig_q};
               `RTS_PERIOD_ADDR: rdata_o <= {8'h0, period_q};
               `RTS_SETTLE_ADDR: rdata_o <= {8'h0, settle_q};
               `RTS_HRES_ADDR: rdata_o <= hres_q;
               `RTS_VRES_ADDR: rdata_o <= vres_q;
               `RTS_XCOORD_ADDR: rdata_o <= x_q;
               `RTS_YCOORD_ADDR: rdata_o <= y_q;
               `RTS_PRESS_ADDR: rdata_o <= {4'h0, press_q};
               default: rdata_o <= 16'h0;
            endcase
         end
      end
   end

endmodule // rts_scanner

// >>> rts_checker.sv
// Port checker for the touch scanner, bound to every instance.
// Assumes the settle count is at least its reset value and one clock.
module rts_checker #(
   parameter [31:0] MS_CYC = 32'd25000
) (
   input wire clock_i,
   input wire rst_i,
   input wire [3:0] addr_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   input wire touch_i,
   input wire adc_start_o,
   input wire [1:0] adc_chan_o,
   input wire [3:0] term_drive_o,
   input wire [3:0] term_oe_o,
   input wire corner_upper_right_o,
   input wire corner_upper_left_o,
   input wire corner_lower_right_o,
   input wire corner_lower_left_o,
   input wire event_alert_n_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   reg rd0_q;
   reg [7:0] idle_q;
   wire rd0 = rd_i && addr_i == 4'h0;
   wire [3:0] corners = {corner_upper_right_o, corner_upper_left_o,
      corner_lower_right_o, corner_lower_left_o};
   // Untouched cycles, saturating
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd0_q <= 1'b0;
         idle_q <= 8'h00;
      end else begin
         rd0_q <= rd0;
         if (touch_i) idle_q <= 8'h00;
         else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
      end
   end
   sequence x_req_s;
      adc_start_o && adc_chan_o == 2'd0;
   endsequence
   sequence settle_s;
      !adc_start_o [*8];
   endsequence
   AST_X_DRIVE: assert property (x_req_s and term_oe_o != 4'h0 |->
      term_oe_o == 4'h3 && term_drive_o[1:0] == 2'b01)
      else $error("four-wire x drive wrong");
   AST_Y_DRIVE: assert property (adc_start_o &&
      adc_chan_o == 2'd1 && term_oe_o != 4'h0 |->
      term_oe_o == 4'hc && term_drive_o[3:2] == 2'b01)
      else $error("four-wire y drive wrong");
   AST_FIVE_X: assert property (x_req_s and term_oe_o == 4'h0 |->
      corners == 4'b1010) else $error("five-wire x corners wrong");
   AST_SETTLE: assert property (adc_start_o |=> settle_s)
      else $error("sample taken before settling");
   AST_STANDBY: assert property (idle_q >= 8'hc8 |-> !adc_start_o)
      else $error("scan while untouched");
   AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside read cycle");
   AST_ALERT_HOLD: assert property (!event_alert_n_o &&
      !rd0 && !rd0_q |=> !event_alert_n_o)
      else $error("alert dropped without read");
   AST_ALERT_RISE: assert property ($rose(event_alert_n_o) |->
      rd0_q || $past(rd0_q)) else $error("alert released without read");
endmodule // rts_checker

bind rts_scanner rts_checker #(.MS_CYC(MS_CYC)) chk (.clock_i(clock_i),
   .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .touch_i(touch_i), .adc_start_o(adc_start_o), .adc_chan_o(adc_chan_o),
   .term_drive_o(term_drive_o), .term_oe_o(term_oe_o),
   .corner_upper_right_o(corner_upper_right_o),
   .corner_upper_left_o(corner_upper_left_o),
   .corner_lower_right_o(corner_lower_right_o),
   .corner_lower_left_o(corner_lower_left_o),
   .event_alert_n_o(event_alert_n_o));

// >>> rts_adc_model.sv
// Converter stand-in: answers each request after a short or long delay.
// Assumes requests are one-cycle pulses on the scanner clock.
module rts_adc_model (
   input wire clock_i,
   input wire slow_i,
   input wire start_i,
   input wire [1:0] chan_i,
   output reg done_o,
   output reg [11:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [3:0] cnt_q;
   reg [1:0] chan_q;
   initial begin
      done_o = 1'b0;
      data_o = 12'h000;
      cnt_q = 4'h0;
      chan_q = 2'd0;
   end
   always @(posedge clock_i) begin
      done_o <= 1'b0;
      // Data is only valid with done; otherwise it keeps changing
      data_o <= ~data_o;
      if (start_i) begin
         cnt_q <= slow_i ? 4'h9 : 4'h1;
         chan_q <= chan_i;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h1) begin
            done_o <= 1'b1;
            data_o <= 12'h800 >> chan_q;
         end
      end
   end
endmodule // rts_adc_model

// >>> rts_scanner_bench.sv
// Self-checking bench for the touch scanner over its register port.
// Assumes the ms count is shortened to 10 cycles.
`include "rts_regs.vh"
module rts_scanner_bench;
   timeunit 1ns;
   timeprecision 1ns;
   reg clock_i, rst_i, wr_i, rd_i, touch_i, five_wire_i, slow, two;
   reg [3:0] addr_i;
   reg [15:0] wdata_i;
   wire [15:0] rdata_o;
   wire [11:0] adc_data_i;
   wire [3:0] term_drive_o, term_oe_o;
   wire [1:0] adc_chan_o;
   wire adc_start_o, adc_done_i, event_alert_n_o;
   integer error_cnt, checks, i;
   rts_scanner #(.MS_CYC(32'd10)) uut (.clock_i(clock_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .touch_i(touch_i), .five_wire_i(five_wire_i),
      .two_touch_i(two), .adc_start_o(adc_start_o),
      .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
      .adc_chan_o(adc_chan_o), .term_drive_o(term_drive_o),
      .term_oe_o(term_oe_o), .corner_upper_right_o(),
      .corner_upper_left_o(), .corner_lower_right_o(),
      .corner_lower_left_o(), .event_alert_n_o(event_alert_n_o));
   rts_adc_model adc (.clock_i(clock_i), .slow_i(slow),
      .start_i(adc_start_o), .chan_i(adc_chan_o), .done_o(adc_done_i),
      .data_o(adc_data_i));
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", checks, error_cnt);
         if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   task cmp_reg(input string nm, input [15:0] e, input [15:0] s);
      begin
         checks = checks + 1;
         if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task cmp_pin(input [0:0] e);
      begin
         checks = checks + 1;
         if (event_alert_n_o !== e) begin
            error_cnt = error_cnt + 1;
            $display("unexpected alert expected %b seen %b", e,
               event_alert_n_o);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clock_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clock_i);
         wr_i <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [15:0] e);
      begin
         @(posedge clock_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge clock_i);
         rd_i <= 1'b0;
         #1;
         cmp_reg("rdata", e, rdata_o);
      end
   endtask
   task wait_alert;
      integer n;
      begin
         n = 0;
         while (event_alert_n_o !== 1'b0 && n < 3000) begin
            @(posedge clock_i);
            #1;
            n = n + 1;
         end
         if (n == 3000) begin
            error_cnt = error_cnt + 1;
            $display("unexpected alert wait expected 0 seen 1");
            report_and_stop;
         end
      end
   endtask
   task touch_off;
      begin
         @(posedge clock_i) touch_i <= 1'b0;
         repeat (300) @(posedge clock_i);
         #1;
      end
   endtask
   initial begin
      {wr_i, rd_i, touch_i, five_wire_i, slow, two} = 6'h00;
      rst_i = 1'b1;
      addr_i = 4'h0;
      wdata_i = 16'h0000;
      error_cnt = 0;
      checks = 0;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(`RTS_PERIOD_ADDR, 16'h000a);
      rd(`RTS_SETTLE_ADDR, 16'h0010);
      rd(`RTS_HRES_ADDR, 16'h1000);
      rd(`RTS_VRES_ADDR, 16'h1000);
      rd(4'hf, 16'h0000);
      wr(`RTS_PERIOD_ADDR, 16'h0003);
      rd(`RTS_PERIOD_ADDR, 16'h0003);
      wr(`RTS_PERIOD_ADDR, 16'h00ff);
      rd(`RTS_PERIOD_ADDR, 16'h00ff);
      wr(`RTS_PERIOD_ADDR, 16'h000a);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`RTS_CFG_ADDR, 16'h0001 << i >> 1);
         rd(`RTS_STAT2_ADDR,
            (i == 0) ? 16'h0 : (i == 1) ? 16'h2 : 16'h4);
      end
      wr(`RTS_CFG_ADDR, 16'h0000);
      $display("test registers done");
      wr(`RTS_TRIG_ADDR, 16'h0003);
      @(posedge clock_i) touch_i <= 1'b1;
      wait_alert;
      rd(`RTS_XCOORD_ADDR, 16'h0800);
      rd(`RTS_YCOORD_ADDR, 16'h0400);
      rd(`RTS_STAT1_ADDR, 16'h0081);
      rd(`RTS_STAT1_ADDR, 16'h0080);
      slow <= 1'b1;
      wait_alert;
      rd(`RTS_STAT1_ADDR, 16'h0081);
      touch_off;
      cmp_pin(1'b0);
      rd(`RTS_STAT1_ADDR, 16'h0003);
      rd(`RTS_XCOORD_ADDR, 16'h0800);
      touch_off;
      cmp_pin(1'b1);
      rd(`RTS_STAT1_ADDR, 16'h0000);
      $display("test touch and release done");
      wr(`RTS_HRES_ADDR, 16'h0400);
      wr(`RTS_VRES_ADDR, 16'h0300);
      wr(`RTS_CFG_ADDR, 16'h0002);
      two <= 1'b1;
      @(posedge clock_i) touch_i <= 1'b1;
      wait_alert;
      rd(`RTS_XCOORD_ADDR, 16'h0200);
      rd(`RTS_YCOORD_ADDR, 16'h00c0);
      rd(`RTS_PRESS_ADDR, 16'h0200);
      rd(`RTS_STAT1_ADDR, 16'h00c1);
      touch_off;
      rd(`RTS_STAT1_ADDR, 16'h0003);
      $display("test resolution done");
      @(posedge clock_i) five_wire_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      wr(`RTS_CFG_ADDR, 16'h0007);
      rd(`RTS_CFG_ADDR, 16'h0000);
      rd(`RTS_STAT2_ADDR, 16'h0001);
      @(posedge clock_i) touch_i <= 1'b1;
      wait_alert;
      rd(`RTS_XCOORD_ADDR, 16'h0200);
      rd(`RTS_STAT1_ADDR, 16'h0081);
      $display("test five-wire done");
      report_and_stop;
   end
endmodule // rts_scanner_bench
